// >>> include/usr_pkg.sv
// shared constants and types for the universal shift register
package usr_pkg;

  // ******************************************************
  // widths and reset values
  // ******************************************************
  localparam int          USR_STAGES    = 4;
  localparam int          USR_BUF_DEPTH = 2;
  localparam logic [3:0]  USR_CLR_VAL   = 4'h0;

  // ******************************************************
  // operating modes, {mode_sel_hi, mode_sel_lo}
  // ******************************************************
  typedef enum logic [1:0] {
    USR_HOLD      = 2'b00,
    USR_SHIFT_RT  = 2'b01,
    USR_SHIFT_LT  = 2'b10,
    USR_LOAD      = 2'b11
  } usr_mode_e;

endpackage : usr_pkg

// >>> core/usr_buf2.sv
// small valid/ready buffer used on the word stream
`timescale 1ns/1ps
module usr_buf2 #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_sys,   // system clock
  input  wire logic             rst,       // async reset, high
  input  wire logic             in_valid,  // word offered
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word in
  output logic                  out_valid, // word waiting
  input  wire logic             out_ready, // receiver takes word
  output logic [WIDTH-1:0]      out_data   // word out, storage read through rd_ptr_q
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ******************************************************
  // storage and pointers
  // ******************************************************
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready  = (count_q != DEPTH[PW:0]);
  assign out_valid = (count_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_ptr_q];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_ptr_q <= '0;
    end else if (pop) begin
      rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end

endmodule : usr_buf2

// >>> core/usr_shift4.sv
// 4-stage bidirectional universal shift register with word stream
// How it works
// - state changes only at rising clock_input edge
// - both mode bits low keeps stored bits
// - both mode bits high loads par_in
// - shift left, serial_in_left enters stage 3
// - shift right, serial_in_right enters stage 0
// - serial inputs ignored outside their direction
// - clear forces par_out low, overrides all
// - clear asynchronous, active on low level
`timescale 1ns/1ps
module usr_shift4
  import usr_pkg::*;
#(
  parameter int STAGES = usr_pkg::USR_STAGES
) (
  input  wire logic              clk_sys,         // system clock
  input  wire logic              rst,             // async reset, high
  input  wire logic              async_clear_n,   // async clear, low
  input  wire logic              clock_input,     // sampled shift clock
  input  wire logic              mode_sel_lo,     // mode bit 0
  input  wire logic              mode_sel_hi,     // mode bit 1
  input  wire logic              serial_in_right, // serial in, stage 0
  input  wire logic              serial_in_left,  // serial in, last
  input  wire logic [STAGES-1:0] par_in,          // parallel data
  output logic [STAGES-1:0]      par_out,         // stored bits
  output logic                   edge_stall,      // edge dropped
  output logic                   word_valid,      // word waiting
  input  wire logic              word_ready,      // receiver takes it
  output logic [STAGES-1:0]      word_data        // updated word
);
  import usr_pkg::*;

  // ******************************************************
  // clock pin edge detection
  // ******************************************************
  logic      clk_pin_q;
  logic      rise;
  logic      take;
  logic      buf_ready;
  usr_mode_e mode;

  // pin is synchronous to clk_sys, so one history flop suffices
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_pin_q <= 1'b0;
    end else begin
      clk_pin_q <= clock_input;
    end
  end

  assign rise = clock_input && !clk_pin_q;
  assign mode = usr_mode_e'({mode_sel_hi, mode_sel_lo});
  // hold edges change nothing, so they never wait on the buffer
  // an edge under clear is swallowed: nothing stored, nothing pushed
  assign edge_stall = rise && async_clear_n && (mode != USR_HOLD)
                      && !buf_ready;
  // a stalled edge is dropped whole: no half update is ever seen
  assign take = rise && async_clear_n && (mode != USR_HOLD)
                && buf_ready;

  // ******************************************************
  // per-stage next value
  // ******************************************************
  logic [STAGES-1:0] stage_q;
  logic [STAGES-1:0] stage_d;

  for (genvar i = 0; i < STAGES; i++) begin : g_stage
    logic from_lower;
    logic from_upper;
    if (i == 0) begin : g_first
      assign from_lower = serial_in_right;
    end else begin : g_mid_lo
      assign from_lower = stage_q[i-1];
    end
    if (i == STAGES - 1) begin : g_last
      assign from_upper = serial_in_left;
    end else begin : g_mid_hi
      assign from_upper = stage_q[i+1];
    end
    always_comb begin
      case (mode)
        USR_SHIFT_RT: stage_d[i] = from_lower;
        USR_SHIFT_LT: stage_d[i] = from_upper;
        USR_LOAD:     stage_d[i] = par_in[i];
        default:      stage_d[i] = stage_q[i];
      endcase
    end
  end

  // ******************************************************
  // storage with asynchronous clear
  // ******************************************************
  always_ff @(posedge clk_sys or posedge rst or negedge async_clear_n)
  begin
    if (rst || !async_clear_n) begin
      stage_q <= STAGES'(USR_CLR_VAL);
    end else if (take) begin
      stage_q <= stage_d;
    end
  end

  assign par_out = stage_q;

  // ******************************************************
  // word stream toward the receiver
  // ******************************************************
  usr_buf2 #(
    .WIDTH (STAGES),
    .DEPTH (USR_BUF_DEPTH)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (take),
    .in_ready  (buf_ready),
    .in_data   (stage_d),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

endmodule : usr_shift4

// >>> verif/usr_sink.sv
// receiver model for the word stream
`timescale 1ns/1ps
module usr_sink (
  input  wire logic       clk_sys,    // clock
  input  wire logic       stall,      // hold off
  input  wire logic       word_valid, // word waiting
  input  wire logic [3:0] word_data,  // word
  output logic            word_ready  // taking
);
  logic [3:0] got[$];
  assign word_ready = !stall;
  always @(posedge clk_sys) begin
    if (word_valid && word_ready) begin
      got.push_back(word_data);
    end
  end
endmodule : usr_sink

// >>> verif/usr_shift4_asserts.sv
// checker on the shift register ports
`timescale 1ns/1ps
module usr_shift4_asserts #(parameter int STAGES = 4) (
  input wire logic              clk_sys,         // clock
  input wire logic              rst,             // reset
  input wire logic              async_clear_n,   // clear
  input wire logic              clock_input,     // shift clock
  input wire logic              mode_sel_lo,     // mode 0
  input wire logic              mode_sel_hi,     // mode 1
  input wire logic              serial_in_right, // right in
  input wire logic              serial_in_left,  // left in
  input wire logic [STAGES-1:0] par_in,          // data
  input wire logic [STAGES-1:0] par_out,         // stages
  input wire logic              edge_stall,      // refused
  input wire logic              word_valid,      // word
  input wire logic [STAGES-1:0] word_data        // word
);
  logic       cin_q;
  logic       ed;
  logic       tk;
  logic [1:0] m;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) cin_q <= 1'b0;
    else cin_q <= clock_input;
  end
  assign m  = {mode_sel_hi, mode_sel_lo};
  assign ed = clock_input && !cin_q;
  assign tk = ed && async_clear_n && !edge_stall && m != 2'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_kept;
    async_clear_n ##1 async_clear_n;
  endsequence
  a_load_all: assert property (
    tk && m == 2'h3 |=> par_out == $past(par_in))
    else $error("load wrong");
  a_shift_rt: assert property (tk && m == 2'h1 |=>
    par_out == {$past(par_out[2:0]), $past(serial_in_right)})
    else $error("right");
  a_shift_lt: assert property (tk && m == 2'h2 |=>
    par_out == {$past(serial_in_left), $past(par_out[3:1])})
    else $error("left");
  a_edge_only: assert property (!ed ##0 s_kept |-> $stable(par_out))
    else $error("moved without edge");
  a_hold_keeps: assert property (
    ed && m == 2'h0 ##0 s_kept |-> $stable(par_out))
    else $error("hold moved");
  a_clear_low: assert property (!async_clear_n |-> par_out == 4'h0)
    else $error("clear ignored");
  a_push_word: assert property (
    tk && !word_valid |=> word_valid && word_data == par_out)
    else $error("word not pushed");
  a_stall_why: assert property (
    edge_stall |-> ed && async_clear_n && m != 2'h0 && word_valid)
    else $error("stall without cause");
endmodule : usr_shift4_asserts
bind usr_shift4 usr_shift4_asserts #(.STAGES(STAGES)) i_usr_shift4_asserts (.*);

// >>> verif/usr_shift4_test.sv
// bench for the shift register and its word stream
`timescale 1ns/1ps
module usr_shift4_test;
  import usr_pkg::*;
  logic clk_sys, rst, async_clear_n, clock_input, mode_sel_lo, mode_sel_hi;
  logic serial_in_right, serial_in_left, word_ready, edge_stall, word_valid;
  logic stall, st;
  logic [3:0] par_in, par_out, word_data;
  logic [3:0] exp_q[$];
  // {mode, right, left, par_in, expected par_out}
  logic [11:0] rows[7] = '{12'hfaa, 12'h605, 12'h5fa, 12'h90d,
                           12'haf6, 12'h3f6, 12'hc99};
  int failures = 0;
  int samples_checked = 0;
  usr_shift4 i_usr_shift4 (.*);
  usr_sink i_usr_sink (.*);
  task automatic chk(string n, logic [3:0] e, logic [3:0] g);
    samples_checked++;
    if (e !== g) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic close_out;
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  // one shift clock edge, mode and data held around it
  task automatic step(logic [11:0] r);
    @(negedge clk_sys);
    {mode_sel_hi, mode_sel_lo, serial_in_right, serial_in_left,
     par_in} = r[11:4];
    clock_input = 1'b1;
    #1 st = edge_stall;
    @(negedge clk_sys) clock_input = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : step
  initial begin
    clk_sys = 0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    close_out;
  end
  initial begin
    {rst, async_clear_n, clock_input, stall, par_in} = 8'hc0;
    {mode_sel_hi, mode_sel_lo, serial_in_right, serial_in_left} = 4'h0;
    repeat (12) @(negedge clk_sys);
    chk("reset", 4'h0, par_out);
    rst = 0;
    foreach (rows[i]) begin
      step(rows[i]);
      chk("par_out", rows[i][3:0], par_out);
      if (rows[i][11:10] != 2'h0) exp_q.push_back(rows[i][3:0]);
    end
    async_clear_n = 0;
    #1 chk("clear", 4'h0, par_out);
    step(12'hcf0);
    chk("clear", 4'h0, par_out);
    async_clear_n = 1;
    // receiver stalls: third word finds the buffer full
    stall = 1;
    step(12'hc11);
    step(12'hc22);
    step(12'hc33);
    chk("stall", 4'h1, {3'h0, st});
    chk("drop", 4'h2, par_out);
    exp_q.push_back(4'h1);
    exp_q.push_back(4'h2);
    stall = 0;
    repeat (4) @(negedge clk_sys);
    chk("empty", 4'h0, {3'h0, word_valid});
    chk("count", 4'(exp_q.size()), 4'(i_usr_sink.got.size()));
    foreach (exp_q[i]) chk("word", exp_q[i], i_usr_sink.got[i]);
    close_out;
  end
endmodule : usr_shift4_test
